// *** inc/dma_req_consts.svh ***
// Register map, field positions, codes and reset values of the request block
//
// Behaviour
// - Each channel picks one of fifteen request sources by a 4-bit field.
// - Code 0 reserved, 1 pin, 2 software, 3-15 on-chip peripheral events.
// - Peripheral requests arrive with the peripheral's interrupt timing.
// - Writing one to a software request bit sets that channel's request.
// - Software request bits clear by themselves once the request is set.
// - With pin source, request pin activity sets the request bit.
// - A request is accepted only while request and enable are both one.
// - Enables reset to zero; software configures first, then enables.
// - Per-channel mode bit zero, the reset value, selects burst mode.
// - Sense bit zero (reset) is edge, one is level; pin burst only.
// - Edge sensing sets the request on a falling edge of the pin.
// - Burst edge request clears on disable, software, completion, terminate.
// - An accepted burst channel locks out all others until it stops.
// - Bus priority: refresh, then hold, then this controller, then CPU.
// - Refresh takes the bus after the current cycle; transfer resumes.
// - After a burst the CPU gets one bus cycle before the next channel.
// - Level sensing: request bit follows the pin, one while it is low.
// - Pin high in level burst stops at a cycle end, enable stays set.
// - Pin low again resumes the level-sensed transfer where it stopped.
// - Level request stays one while pin is low, even after completion.
// - Mode one is cycle steal; request clears at each transfer cycle start.
// - Fixed priority, channel 0 highest; burst decides at first acceptance.
`ifndef DMA_REQ_CONSTS_SVH
`define DMA_REQ_CONSTS_SVH

`define OFS_GCTRL    8'h00
`define OFS_SWREQ    8'h04
`define OFS_REQEN    8'h08
`define OFS_CHCTL0   8'h10

`define F_PRIO       0
`define F_EN_LSB     4
`define F_ACT_LSB    8
`define F_ACTV       10
`define F_OWN_LSB    11
`define F_SENSE      4
`define F_MODE       10

`define SRC_RSVD     4'h0
`define SRC_EXT      4'h1
`define SRC_SW       4'h2
`define SRC_TA0      4'h3
`define N_PERIPH     13

`define SENSE_LEVEL  1'b1
`define MODE_STEAL   1'b1

`define RST_SRC      4'h0
`define RST_SENSE    1'b0
`define RST_MODE     1'b0
`define RST_EN       1'b0
`define RST_PRIO     1'b0

`endif

// *** inc/dma_req_pkg.sv ***
// Types shared by the request control block
package dma_req_pkg;

  typedef enum logic [1:0] {
    OWN_CPU     = 2'b00,
    OWN_DMA     = 2'b01,
    OWN_HOLD    = 2'b10,
    OWN_REFRESH = 2'b11
  } owner_e;

  typedef logic [3:0] src_t;

endpackage : dma_req_pkg

// *** inc/pin_sync_if.sv ***
// Synchronised pin levels and falling-edge pulses between the two modules
`timescale 1ns/1ps
interface pin_sync_if #(
  parameter int N = 5
);
  logic [N-1:0] low;
  logic [N-1:0] fall;

  modport src (output low, output fall);
  modport dst (input  low, input  fall);
endinterface : pin_sync_if

// *** design/pin_sync.sv ***
// Three-stage synchroniser with falling-edge detect for active-low pins
`timescale 1ns/1ps
module pin_sync #(
  parameter int N = 5
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic [N-1:0] pin_n_i,
  pin_sync_if.src           sy
);

  logic [N-1:0] s1_r;
  logic [N-1:0] s2_r;
  logic [N-1:0] s3_r;
  logic [N-1:0] lvl_r;
  logic [N-1:0] fall_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_r <= '1;
      s2_r <= '1;
      s3_r <= '1;
    end else begin
      s1_r <= pin_n_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // Change accepted only when stages two and three agree
  for (genvar b = 0; b < N; b++) begin : g_bit
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        lvl_r[b]  <= 1'b1;
        fall_r[b] <= 1'b0;
      end else begin
        fall_r[b] <= (s2_r[b] == s3_r[b]) && lvl_r[b] && !s3_r[b];
        if (s2_r[b] == s3_r[b]) begin
          lvl_r[b] <= s3_r[b];
        end
      end
    end
  end

  assign sy.low  = ~lvl_r;
  assign sy.fall = fall_r;

endmodule : pin_sync

// *** design/transfer_controller.sv ***
// Four-channel transfer request, acceptance and bus hand-over control
`timescale 1ns/1ps
`include "dma_req_consts.svh"
module transfer_controller import dma_req_pkg::*; #(
  parameter int NCH   = 4,
  parameter int ADR_W = 8
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             cyc_i,
  input  wire logic             stb_i,
  input  wire logic             we_i,
  input  wire logic [ADR_W-1:0] adr_i,
  input  wire logic [3:0]       sel_i,
  input  wire logic [31:0]      dat_i,
  output logic      [31:0]      dat_o,
  output logic                  ack_o,
  input  wire logic [NCH-1:0]   transfer_request_pin_n_i,
  input  wire logic             terminate_count_pin_n_i,
  input  wire logic [12:0]      periph_evt_i,
  input  wire logic             refresh_req_i,
  input  wire logic             hold_req_i,
  input  wire logic             bus_cycle_end_i,
  input  wire logic             last_xfer_i,
  output logic      [1:0]       bus_owner_o,
  output logic                  dma_grant_o,
  output logic      [1:0]       channel_n_o
);

  localparam int CW = 2;

  if (NCH != 4) begin : g_bad_nch
    $error("transfer_controller: NCH must be 4");
  end
  if (ADR_W < 8) begin : g_bad_adr
    $error("transfer_controller: ADR_W must be at least 8");
  end

  // Bus slave state
  logic          ack_r;
  logic [31:0]   rdat_r;
  logic [31:0]   rd_word;
  logic          bus_req;
  logic          wr;
  logic [7:0]    adr8;
  logic          chctl_hit;
  logic [CW-1:0] chctl_idx;
  logic          wr_gctrl;
  logic          wr_sw;
  logic          wr_reqen;

  // Control and channel state
  logic           prio_r;
  owner_e         owner_r;
  owner_e         owner_nxt;
  logic [CW-1:0]  chan_r;
  logic           act_v_r;
  logic [CW-1:0]  act_ch_r;
  logic           cpu_turn_r;
  logic [NCH-1:0] req_v;
  logic [NCH-1:0] en_v;
  logic [NCH-1:0] sw_v;
  logic [NCH-1:0] mode_v;
  logic [NCH-1:0] elig;
  logic [NCH-1:0] done_v;
  logic [NCH-1:0] tc_stop_v;
  logic [NCH-1:0] cs_start_v;
  src_t           src_a   [NCH];
  logic           sense_a [NCH];
  logic           pick_v;
  logic [CW-1:0]  pick;
  logic           stop_now;
  logic           grant_dma;
  logic           act_release;

  pin_sync_if #(.N(NCH + 1)) sy ();

  pin_sync #(
    .N (NCH + 1)
  ) u_sync (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .pin_n_i ({terminate_count_pin_n_i, transfer_request_pin_n_i}),
    .sy      (sy)
  );

  // One wait state; a write lands on the edge that samples ack
  assign bus_req   = cyc_i & stb_i & ~ack_r;
  assign wr        = cyc_i & stb_i & ack_r & we_i;
  assign adr8      = adr_i[7:0];
  assign chctl_hit = (adr8 >= `OFS_CHCTL0)
                   && (adr8 < (`OFS_CHCTL0 + 8'(NCH * 4)))
                   && (adr8[1:0] == 2'h0);
  assign chctl_idx = CW'((adr8 - `OFS_CHCTL0) >> 2);
  assign wr_gctrl  = wr & sel_i[0] & (adr8 == `OFS_GCTRL);
  assign wr_sw     = wr & sel_i[0] & (adr8 == `OFS_SWREQ);
  assign wr_reqen  = wr & sel_i[0] & (adr8 == `OFS_REQEN);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r  <= 1'b0;
      rdat_r <= 32'h0000_0000;
    end else begin
      ack_r <= bus_req;
      if (bus_req && !we_i) begin
        rdat_r <= rd_word;
      end
    end
  end

  assign ack_o = ack_r;
  assign dat_o = rdat_r;

  // Unmapped offsets in adr_i[7:0] read zero and ignore writes; upper address bits are not decoded
  always_comb begin
    rd_word = 32'h0000_0000;
    if (adr8 == `OFS_GCTRL) begin
      rd_word[`F_PRIO] = prio_r;
    end else if (adr8 == `OFS_SWREQ) begin
      rd_word[NCH-1:0] = sw_v;
    end else if (adr8 == `OFS_REQEN) begin
      rd_word[NCH-1:0]                 = req_v;
      rd_word[`F_EN_LSB +: NCH]        = en_v;
      rd_word[`F_ACT_LSB +: CW]        = act_ch_r;
      rd_word[`F_ACTV]                 = act_v_r;
      rd_word[`F_OWN_LSB +: 2]         = owner_r;
    end else if (chctl_hit) begin
      rd_word[3:0]      = src_a[chctl_idx];
      rd_word[`F_SENSE] = sense_a[chctl_idx];
      rd_word[`F_MODE]  = mode_v[chctl_idx];
    end
  end

  // Rotation is not built; the select bit is kept for software only
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prio_r <= `RST_PRIO;
    end else if (wr_gctrl) begin
      prio_r <= dat_i[`F_PRIO];
    end
  end

  // Events that clear a channel's request: run end or terminate while it owns the bus, and the steal-mode grant
  for (genvar i = 0; i < NCH; i++) begin : g_stop
    assign done_v[i]    = bus_cycle_end_i && last_xfer_i
                        && (owner_r == OWN_DMA) && (chan_r == CW'(i));
    assign tc_stop_v[i] = sy.low[NCH] && (owner_r == OWN_DMA)
                        && (chan_r == CW'(i));
    assign cs_start_v[i] = grant_dma && (pick == CW'(i)) && mode_v[i];
  end

  for (genvar i = 0; i < NCH; i++) begin : g_ch
    src_t src_q;
    logic sense_q;
    logic mode_q;
    logic en_q;
    logic req_q;
    logic sw_q;
    logic wr_ch;
    logic en_nxt;
    logic is_ext;
    logic level;
    logic periph_hit;
    logic set_req;
    logic clr_req;

    assign wr_ch  = wr && chctl_hit && (chctl_idx == CW'(i));
    assign is_ext = (src_q == `SRC_EXT);
    // level only for pin in burst
    assign level  = is_ext && (sense_q == `SENSE_LEVEL)
                  && (mode_q != `MODE_STEAL);

    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        src_q   <= `RST_SRC;
        sense_q <= `RST_SENSE;
      end else if (wr_ch && sel_i[0]) begin
        src_q   <= dat_i[3:0];
        sense_q <= dat_i[`F_SENSE];
      end
    end

    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        mode_q <= `RST_MODE;
      end else if (wr_ch && sel_i[1]) begin
        mode_q <= dat_i[`F_MODE];
      end
    end

    always_comb begin
      en_nxt = en_q;
      if (wr_reqen) begin
        en_nxt = dat_i[`F_EN_LSB + i];
      end
      if (done_v[i]) begin
        en_nxt = 1'b0;
      end
    end

    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        en_q <= `RST_EN;
      end else begin
        en_q <= en_nxt;
      end
    end

    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        sw_q <= 1'b0;
      end else begin
        sw_q <= (wr_sw && dat_i[i]) || (sw_q && !req_q);
      end
    end

    // code 3 upward maps to events
    assign periph_hit = (src_q >= `SRC_TA0)
                     && periph_evt_i[4'(src_q - `SRC_TA0)];

    assign set_req = (is_ext && !level && sy.fall[i])
                   || ((src_q == `SRC_SW) && sw_q)
                   || periph_hit;

    assign clr_req = (en_q && !en_nxt)
                   || (wr_reqen && !dat_i[i])
                   || done_v[i]
                   || tc_stop_v[i]
                   || cs_start_v[i];

    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        req_q <= 1'b0;
      end else if (level) begin
        req_q <= sy.low[i];
      end else if (set_req) begin
        req_q <= 1'b1;
      end else if (clr_req) begin
        req_q <= 1'b0;
      end
    end

    assign src_a[i]   = src_q;
    assign sense_a[i] = sense_q;
    assign mode_v[i]  = mode_q;
    assign en_v[i]    = en_q;
    assign req_v[i]   = req_q;
    assign sw_v[i]    = sw_q;
  end

  assign elig = req_v & en_v;

  // active burst channel holds the choice
  always_comb begin
    pick_v = 1'b0;
    pick   = '0;
    for (int k = NCH - 1; k >= 0; k--) begin
      if (elig[k]) begin
        pick_v = 1'b1;
        pick   = CW'(k);
      end
    end
    if (act_v_r) begin
      pick_v = elig[act_ch_r];
      pick   = act_ch_r;
    end
  end

  assign stop_now = |(done_v | tc_stop_v);

  // CPU gets the bus after a run
  always_comb begin
    if (refresh_req_i) begin
      owner_nxt = OWN_REFRESH;
    end else if (hold_req_i) begin
      owner_nxt = OWN_HOLD;
    end else if (stop_now || (cpu_turn_r && owner_r != OWN_CPU)) begin
      owner_nxt = OWN_CPU;
    end else if (pick_v) begin
      owner_nxt = OWN_DMA;
    end else begin
      owner_nxt = OWN_CPU;
    end
  end

  assign grant_dma = bus_cycle_end_i && (owner_nxt == OWN_DMA);

  // owner changes only at cycle end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      owner_r <= OWN_CPU;
    end else if (bus_cycle_end_i) begin
      owner_r <= owner_nxt;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      chan_r <= '0;
    end else if (grant_dma) begin
      chan_r <= pick;
    end
  end

  assign act_release = act_v_r && (stop_now || !elig[act_ch_r]);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      act_v_r  <= 1'b0;
      act_ch_r <= '0;
    end else if (act_release) begin
      act_v_r <= 1'b0;
    end else if (grant_dma && !act_v_r && !mode_v[pick]) begin
      act_v_r  <= 1'b1;
      act_ch_r <= pick;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cpu_turn_r <= 1'b0;
    end else if (act_release) begin
      cpu_turn_r <= 1'b1;
    end else if (bus_cycle_end_i && owner_r == OWN_CPU) begin
      cpu_turn_r <= 1'b0;
    end
  end

  assign bus_owner_o = owner_r;
  assign dma_grant_o = (owner_r == OWN_DMA);
  assign channel_n_o = chan_r;

endmodule : transfer_controller

// *** tb/dma_req_checker.sv ***
// Port-level assertions for the transfer request controller
`timescale 1ns/1ps
module dma_req_checker import dma_req_pkg::*; #(
  parameter int ADR_W = 8
) (
  input wire logic             clk_i,
  input wire logic             rst_i,
  input wire logic             cyc_i,
  input wire logic             stb_i,
  input wire logic             we_i,
  input wire logic [ADR_W-1:0] adr_i,
  input wire logic [31:0]      dat_o,
  input wire logic             ack_o,
  input wire logic             refresh_req_i,
  input wire logic             hold_req_i,
  input wire logic             bus_cycle_end_i,
  input wire logic             last_xfer_i,
  input wire logic [1:0]       bus_owner_o,
  input wire logic             dma_grant_o,
  input wire logic [1:0]       channel_n_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  ack_one_cycle_a: assert property (
    cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o)
    else $error("bus answer not a single cycle pulse");
  unmapped_read_zero_a: assert property (cyc_i && stb_i && !we_i && !ack_o
    && adr_i >= 8'h20 |=> dat_o == 32'h0)
    else $error("unmapped read not zero");
  grant_yields_a: assert property (bus_cycle_end_i
    && (refresh_req_i || hold_req_i) |=> !dma_grant_o)
    else $error("transfer kept the bus over a higher user");
  owner_holds_a: assert property (!bus_cycle_end_i |=> $stable(bus_owner_o))
    else $error("owner moved outside a cycle end");
  refresh_first_a: assert property (
    bus_cycle_end_i && refresh_req_i |=> bus_owner_o == OWN_REFRESH)
    else $error("refresh not given the bus");
  hold_next_a: assert property (bus_cycle_end_i && !refresh_req_i
    && hold_req_i |=> bus_owner_o == OWN_HOLD)
    else $error("hold not given the bus");
  cpu_after_burst_a: assert property (bus_cycle_end_i && last_xfer_i
    && dma_grant_o && !refresh_req_i && !hold_req_i |=> bus_owner_o == OWN_CPU)
    else $error("bus not returned to the processor");
  channel_locked_a: assert property (
    !bus_cycle_end_i |=> $stable(channel_n_o))
    else $error("channel moved outside a cycle end");

  cover property (dma_grant_o);
  cover property (bus_owner_o == OWN_REFRESH);
  cover property (bus_owner_o == OWN_HOLD);
endmodule : dma_req_checker

bind transfer_controller dma_req_checker #(.ADR_W(ADR_W)) i_dma_req_checker (
  .clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .dat_o, .ack_o,
  .refresh_req_i, .hold_req_i, .bus_cycle_end_i, .last_xfer_i,
  .bus_owner_o, .dma_grant_o, .channel_n_o);

// *** tb/bus_partner.sv ***
// Bus cycle pacing and transfer count model on the far side
`timescale 1ns/1ps
module bus_partner #(
  parameter int CYC = 3,
  parameter int LEN = 12
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic dma_grant_i,
  output logic      bus_cycle_end_o,
  output logic      last_xfer_o
);
  logic [7:0] tick_r;
  logic [7:0] done_r;

  always_ff @(posedge clk_i) begin
    if (rst_i || bus_cycle_end_o) tick_r <= 8'h00;
    else tick_r <= tick_r + 8'h01;
  end
  assign bus_cycle_end_o = (tick_r == 8'(CYC - 1));

  always_ff @(posedge clk_i) begin
    if (rst_i) done_r <= 8'h00;
    else if (bus_cycle_end_o && dma_grant_i)
      done_r <= last_xfer_o ? 8'h00 : done_r + 8'h01;
  end
  assign last_xfer_o = dma_grant_i && (done_r == 8'(LEN - 1));
endmodule : bus_partner

// *** tb/testbench.sv ***
// Self-checking bench for the transfer request controller
`timescale 1ns/1ps
module testbench import dma_req_pkg::*; ;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc_i = 1'b0;
  logic        stb_i = 1'b0;
  logic        we_i = 1'b0;
  logic [7:0]  adr_i = 8'h00;
  logic [31:0] dat_i = 32'h0;
  logic [3:0]  pin_n = 4'hF;
  logic        term_n = 1'b1;
  logic [12:0] evt = 13'h0;
  logic        refresh = 1'b0;
  logic        hold = 1'b0;
  logic [31:0] dat_o;
  logic [31:0] rd;
  logic        ack_o, cyc_end, last, grant;
  logic [1:0]  owner, chan;
  int          errors = 0;
  int          total_checks = 0;
  int          cycles = 0;

  always #2.5 clk_i = ~clk_i;

  transfer_controller i_transfer_controller (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(4'hF), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .transfer_request_pin_n_i(pin_n), .terminate_count_pin_n_i(term_n),
    .periph_evt_i(evt), .refresh_req_i(refresh), .hold_req_i(hold),
    .bus_cycle_end_i(cyc_end), .last_xfer_i(last), .bus_owner_o(owner),
    .dma_grant_o(grant), .channel_n_o(chan));

  bus_partner #(.CYC(3), .LEN(12)) i_bus_partner (
    .clk_i(clk_i), .rst_i(rst_i), .dma_grant_i(grant),
    .bus_cycle_end_o(cyc_end), .last_xfer_o(last));

  task automatic report_and_stop;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Request held until the ack edge, then one idle cycle
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    @(posedge clk_i);
    while (ack_o !== 1'b1 && n < 20) begin
      @(posedge clk_i);
      n++;
    end
    rd = dat_o;
    chk(32'(ack_o), 32'h1);
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clk_i);
  endtask : wb

  task automatic wait_own(input logic [1:0] e);
    int n;
    n = 0;
    while (owner !== e && n < 300) begin
      @(posedge clk_i);
      n++;
    end
    chk(32'(owner), 32'(e));
  endtask : wait_own

  always @(posedge clk_i) begin
    cycles++;
    if (cycles > 20000) begin
      errors++;
      $display("ERROR %0t: run too long", $time);
      report_and_stop();
    end
  end

  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    wb(1'b0, 8'h08, 32'h0); chk(rd, 32'h0);
    wb(1'b0, 8'h10, 32'h0); chk(rd, 32'h0);
    wb(1'b0, 8'hFC, 32'h0); chk(rd, 32'h0);
    $display("test reset done");
    wb(1'b1, 8'h18, 32'h2);
    wb(1'b1, 8'h08, 32'h40);
    wb(1'b1, 8'h04, 32'h4);
    wait_own(OWN_DMA); chk(32'(chan), 32'h2);
    wb(1'b0, 8'h04, 32'h0); chk(rd, 32'h0);
    wait_own(OWN_CPU);
    wb(1'b0, 8'h08, 32'h0); chk(rd & 32'h04FF, 32'h0);
    $display("test software done");
    wb(1'b1, 8'h14, 32'h1);
    wb(1'b1, 8'h10, 32'h1);
    pin_n[1] <= 1'b0;
    repeat (20) @(posedge clk_i);
    chk(32'(grant), 32'h0);
    wb(1'b0, 8'h08, 32'h0); chk(rd & 32'hFF, 32'h2);
    wb(1'b1, 8'h08, 32'h33);
    wait_own(OWN_DMA); chk(32'(chan), 32'h1);
    pin_n[0] <= 1'b0;
    repeat (9) @(posedge clk_i);
    chk(32'(chan), 32'h1);
    wait_own(OWN_CPU);
    wait_own(OWN_DMA); chk(32'(chan), 32'h0);
    pin_n <= 4'hF;
    refresh <= 1'b1;
    wait_own(OWN_REFRESH);
    refresh <= 1'b0;
    wait_own(OWN_DMA); chk(32'(chan), 32'h0);
    hold <= 1'b1;
    wait_own(OWN_HOLD);
    hold <= 1'b0;
    wait_own(OWN_DMA);
    term_n <= 1'b0;
    wait_own(OWN_CPU);
    term_n <= 1'b1;
    wb(1'b0, 8'h08, 32'h0); chk(rd & 32'h1, 32'h0);
    $display("test burst done");
    wb(1'b1, 8'h1C, 32'h11);
    wb(1'b1, 8'h08, 32'h80);
    pin_n[3] <= 1'b0;
    wait_own(OWN_DMA); chk(32'(chan), 32'h3);
    pin_n[3] <= 1'b1;
    wait_own(OWN_CPU);
    wb(1'b0, 8'h08, 32'h0); chk(rd & 32'hFF, 32'h80);
    pin_n[3] <= 1'b0;
    wait_own(OWN_DMA); chk(32'(chan), 32'h3);
    wait_own(OWN_CPU);
    wb(1'b0, 8'h08, 32'h0); chk(rd & 32'h8, 32'h8);
    pin_n[3] <= 1'b1;
    $display("test level done");
    wb(1'b1, 8'h14, 32'h0);
    wb(1'b1, 8'h08, 32'h20);
    evt <= 13'h1FFF;
    @(posedge clk_i);
    evt <= 13'h0;
    repeat (12) @(posedge clk_i);
    chk(32'(grant), 32'h0);
    for (int k = 0; k < 13; k++) begin
      wb(1'b1, 8'h18, 32'(k + 3));
      wb(1'b1, 8'h08, 32'h40);
      evt[k] <= 1'b1;
      @(posedge clk_i);
      evt[k] <= 1'b0;
      wait_own(OWN_DMA); chk(32'(chan), 32'h2);
      wait_own(OWN_CPU);
    end
    $display("test peripheral done");
    wb(1'b1, 8'h18, 32'h402);
    wb(1'b1, 8'h08, 32'h40);
    wb(1'b1, 8'h04, 32'h4);
    wait_own(OWN_DMA); chk(32'(chan), 32'h2);
    wait_own(OWN_CPU);
    wb(1'b0, 8'h08, 32'h0); chk(rd & 32'h444, 32'h40);
    $display("test steal done");
    report_and_stop();
  end
endmodule : testbench
